// >>> rtl/io_ports_pkg.sv
package io_ports_pkg;

	// register bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// port widths
	localparam int unsigned WIDE_PORT_W   = 8;
	localparam int unsigned NARROW_PORT_W = 6;

	// register offsets
	localparam logic [7:0] OFS_PORT_A_DATA = 8'h00;
	localparam logic [7:0] OFS_PORT_A_DIR  = 8'h01;
	localparam logic [7:0] OFS_PORT_B_DATA = 8'h02;
	localparam logic [7:0] OFS_PORT_B_DIR  = 8'h03;
	localparam logic [7:0] OFS_PORT_C_DATA = 8'h04;
	localparam logic [7:0] OFS_PORT_C_DIR  = 8'h05;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h06;
	localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h07;
	localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h08;

	// reset values
	localparam logic [7:0] RST_WIDE_DATA   = 8'h00;
	localparam logic [7:0] RST_WIDE_DIR    = 8'h00;
	localparam logic [5:0] RST_NARROW_DATA = 6'h00;
	localparam logic [5:0] RST_NARROW_DIR  = 6'h00;
	localparam logic [5:0] RST_IRQ_STATUS  = 6'h00;
	localparam logic [5:0] RST_IRQ_ENABLE  = 6'h00;
	localparam logic [5:0] RST_EDGE_PREV   = 6'h3f;

	// third port field positions of the shared timer pins
	localparam int unsigned BIT_CAPTURE = 0;
	localparam int unsigned BIT_COMPARE = 1;

	// watchdog reset pulse on the reset pin: 1.5 core cycles least
	localparam int unsigned DOG_PULSE_TENTHS = 15;
	localparam int unsigned DOG_PULSE_CYCLES = (DOG_PULSE_TENTHS + 9) / 10;
	localparam int unsigned DOG_CNT_W        = 2;

	// state of the reset pin driver
	typedef enum logic [1:0] {
		PIN_IDLE  = 2'b01,
		PIN_PULSE = 2'b10
	} reset_pin_state_t;

endpackage : io_ports_pkg

// >>> rtl/three_port_io_with_wakeup.sv
// Notes on behaviour
// (R1) first port: eight lines, per-bit direction
// (R2) build option: first port push-pull or open-drain
// (R3) second port: eight lines, per-bit direction
// (R4) third port: six lines, direction and data
// (R5) wake-up option: falling-edge interrupts, one vector
// (R6) without wake-up: plain inputs with pull-ups; code drives lines whose direction bit is one, except timer-owned pins, pull-ups only on undriven lines
// (R7) third-port falling edge wakes wait or halt
// (R8) capture option: bit zero feeds timer, no pull-up
// (R9) compare option: bit one from timer, no pull-up
// (R10) reset pin resets device; watchdog drives it low
// (R11) direction one drives latch; zero reads pin
`timescale 1ns/1ps
`default_nettype none

module three_port_io_with_wakeup #(
	parameter bit WAKEUP_OPTION     = 1'b1,
	parameter bit OPEN_DRAIN_OPTION = 1'b0,
	parameter bit CAPTURE_OPTION    = 1'b1,
	parameter bit COMPARE_OPTION    = 1'b1
) (
	// clock and reset
	input  wire logic                                   i_clock,
	input  wire logic                                   i_resetn,
	// register port
	input  wire logic [io_ports_pkg::ADDR_W-1:0]        i_addr,
	input  wire logic [io_ports_pkg::DATA_W-1:0]        i_wdata,
	input  wire logic                                   i_write,
	input  wire logic                                   i_read,
	output logic      [io_ports_pkg::DATA_W-1:0]        o_rdata,
	// first port pins
	input  wire logic [io_ports_pkg::WIDE_PORT_W-1:0]   i_first_port_lines,
	output logic      [io_ports_pkg::WIDE_PORT_W-1:0]   o_first_port_lines,
	output logic      [io_ports_pkg::WIDE_PORT_W-1:0]   o_first_port_lines_oe,
	// second port pins
	input  wire logic [io_ports_pkg::WIDE_PORT_W-1:0]   i_second_port_lines,
	output logic      [io_ports_pkg::WIDE_PORT_W-1:0]   o_second_port_lines,
	output logic      [io_ports_pkg::WIDE_PORT_W-1:0]   o_second_port_lines_oe,
	// third port pins
	input  wire logic [io_ports_pkg::NARROW_PORT_W-1:0] i_third_port_lines,
	output logic      [io_ports_pkg::NARROW_PORT_W-1:0] o_third_port_lines,
	output logic      [io_ports_pkg::NARROW_PORT_W-1:0] o_third_port_lines_oe,
	output logic      [io_ports_pkg::NARROW_PORT_W-1:0] o_third_port_pullup_en,
	// timer connections
	output logic                                        o_timer_capture_input,
	input  wire logic                                   i_timer_compare_output_one,
	// interrupt and wake-up
	output logic                                        o_irq,
	output logic                                        o_wakeup,
	// reset pin and watchdog
	input  wire logic                                   i_reset_pin_n,
	output logic                                        o_reset_pin,
	output logic                                        o_reset_pin_oe,
	input  wire logic                                   i_watchdog_reset,
	output logic                                        o_device_reset_n
);

	////////////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta_r;
	logic rst_sync_r;
	logic rstn;

	// async assert, release through two flops
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	// every flop below resets on this copy, never on the raw pin
	assign rstn = rst_sync_r;

	////////////////////////////////////////////////////////////////////////////////
	// register decode

	logic wr_a_data;
	logic wr_a_dir;
	logic wr_b_data;
	logic wr_b_dir;
	logic wr_c_data;
	logic wr_c_dir;
	logic wr_clear;
	logic wr_enable;

	// status and unmapped offsets decode to nothing, so writes there drop
	assign wr_a_data = i_write && (i_addr == io_ports_pkg::OFS_PORT_A_DATA);
	assign wr_a_dir  = i_write && (i_addr == io_ports_pkg::OFS_PORT_A_DIR);
	assign wr_b_data = i_write && (i_addr == io_ports_pkg::OFS_PORT_B_DATA);
	assign wr_b_dir  = i_write && (i_addr == io_ports_pkg::OFS_PORT_B_DIR);
	assign wr_c_data = i_write && (i_addr == io_ports_pkg::OFS_PORT_C_DATA);
	assign wr_c_dir  = i_write && (i_addr == io_ports_pkg::OFS_PORT_C_DIR);
	assign wr_clear  = i_write && (i_addr == io_ports_pkg::OFS_IRQ_CLEAR);
	assign wr_enable = i_write && (i_addr == io_ports_pkg::OFS_IRQ_ENABLE);

	////////////////////////////////////////////////////////////////////////////////
	// port data and direction latches

	logic [7:0] port_a_data_reg_r;
	logic [7:0] port_a_direction_reg_r;
	logic [7:0] port_b_data_reg_r;
	logic [7:0] port_b_direction_reg_r;
	logic [5:0] port_c_data_reg_r;
	logic [5:0] port_c_direction_reg_r;

	// first port latches
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			port_a_data_reg_r      <= io_ports_pkg::RST_WIDE_DATA;
			port_a_direction_reg_r <= io_ports_pkg::RST_WIDE_DIR;
		end else begin
			if (wr_a_data) begin
				port_a_data_reg_r <= i_wdata; // R1
			end
			if (wr_a_dir) begin
				port_a_direction_reg_r <= i_wdata; // R1
			end
		end
	end

	// second port latches
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			port_b_data_reg_r      <= io_ports_pkg::RST_WIDE_DATA;
			port_b_direction_reg_r <= io_ports_pkg::RST_WIDE_DIR;
		end else begin
			if (wr_b_data) begin
				port_b_data_reg_r <= i_wdata; // R3
			end
			if (wr_b_dir) begin
				port_b_direction_reg_r <= i_wdata; // R3
			end
		end
	end

	// third port latches, only six bits kept
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			port_c_data_reg_r      <= io_ports_pkg::RST_NARROW_DATA;
			port_c_direction_reg_r <= io_ports_pkg::RST_NARROW_DIR;
		end else begin
			if (wr_c_data) begin
				port_c_data_reg_r <= i_wdata[5:0]; // R4
			end
			if (wr_c_dir) begin
				port_c_direction_reg_r <= i_wdata[5:0]; // R4
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drivers

	// open drain only ever pulls low; a one in the latch releases the line
	always_comb begin
		if (OPEN_DRAIN_OPTION) begin
			o_first_port_lines    = 8'h00; // R2
			o_first_port_lines_oe = port_a_direction_reg_r & ~port_a_data_reg_r; // R2
		end else begin
			o_first_port_lines    = port_a_data_reg_r; // R11
			o_first_port_lines_oe = port_a_direction_reg_r; // R2
		end
	end

	// second port is always push-pull; only the first has the open-drain build
	assign o_second_port_lines    = port_b_data_reg_r; // R11
	assign o_second_port_lines_oe = port_b_direction_reg_r; // R11

	logic [5:0] c_line_is_output;
	logic [5:0] c_line_timer_owned;

	// per-line ownership of the third port
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_third
			always_comb begin
				c_line_timer_owned[gi] = 1'b0;
				if (gi == io_ports_pkg::BIT_CAPTURE && CAPTURE_OPTION) begin
					c_line_timer_owned[gi] = 1'b1; // R8
				end
				if (gi == io_ports_pkg::BIT_COMPARE && COMPARE_OPTION) begin
					c_line_timer_owned[gi] = 1'b1; // R9
				end
				// interrupt lines other than the compare pin stay inputs whatever the latch says
				c_line_is_output[gi] = port_c_direction_reg_r[gi] && !WAKEUP_OPTION; // R5
				o_third_port_lines[gi]    = port_c_data_reg_r[gi]; // R11
				o_third_port_lines_oe[gi] = c_line_is_output[gi] && !c_line_timer_owned[gi];
				if (gi == io_ports_pkg::BIT_COMPARE && COMPARE_OPTION) begin
					o_third_port_lines[gi]    = i_timer_compare_output_one; // R9
					o_third_port_lines_oe[gi] = 1'b1; // R9
				end
				// pull-up only on a line that is an input and not a timer pin
				o_third_port_pullup_en[gi] = !o_third_port_lines_oe[gi]
					&& !c_line_timer_owned[gi]; // R6
			end
		end
	endgenerate

	// capture pin routes straight to the timer
	// with the option off the timer sees an idle high level
	assign o_timer_capture_input = CAPTURE_OPTION ? i_third_port_lines[io_ports_pkg::BIT_CAPTURE]
		: 1'b1; // R8

	////////////////////////////////////////////////////////////////////////////////
	// falling edge detection and interrupt

	logic [5:0] c_prev_r;
	logic [5:0] c_fall;
	logic [5:0] irq_status_r;
	logic [5:0] irq_enable_r;

	// previous level; starts high so a line low at reset counts as a falling edge
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			c_prev_r <= io_ports_pkg::RST_EDGE_PREV;
		end else begin
			c_prev_r <= i_third_port_lines;
		end
	end

	// without the wake-up build no edge is seen, so status stays clear
	assign c_fall = WAKEUP_OPTION ? (c_prev_r & ~i_third_port_lines) : 6'h00; // R5

	// sticky status; a new edge beats a clear in the same cycle
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			irq_status_r <= io_ports_pkg::RST_IRQ_STATUS;
		end else begin
			irq_status_r <= (irq_status_r & ~(wr_clear ? i_wdata[5:0] : 6'h00)) | c_fall; // R5
		end
	end

	// enable mask
	// a masked line still records its edge, it only stays off the request
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			irq_enable_r <= io_ports_pkg::RST_IRQ_ENABLE;
		end else if (wr_enable) begin
			irq_enable_r <= i_wdata[5:0];
		end
	end

	// all six lines share the one request
	// level output: drops once software clears or masks the bit
	assign o_irq = |(irq_status_r & irq_enable_r); // R5

	// wake pulse one cycle after the edge, independent of the mask
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			o_wakeup <= 1'b0;
		end else begin
			o_wakeup <= |c_fall; // R7
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path

	logic [7:0] rd_nxt;

	// output bits read the latch, input bits the pin
	// reads have no side effect; status clears only through the separate clear offset
	always_comb begin
		rd_nxt = 8'h00;
		unique case (i_addr)
			io_ports_pkg::OFS_PORT_A_DATA: rd_nxt = (port_a_direction_reg_r & port_a_data_reg_r)
				| (~port_a_direction_reg_r & i_first_port_lines); // R11
			io_ports_pkg::OFS_PORT_A_DIR:  rd_nxt = port_a_direction_reg_r;
			io_ports_pkg::OFS_PORT_B_DATA: rd_nxt = (port_b_direction_reg_r & port_b_data_reg_r)
				| (~port_b_direction_reg_r & i_second_port_lines); // R11
			io_ports_pkg::OFS_PORT_B_DIR:  rd_nxt = port_b_direction_reg_r;
			io_ports_pkg::OFS_PORT_C_DATA: rd_nxt = {2'b00,
				(c_line_is_output & port_c_data_reg_r)
				| (~c_line_is_output & i_third_port_lines)}; // R11
			io_ports_pkg::OFS_PORT_C_DIR:  rd_nxt = {2'b00, port_c_direction_reg_r};
			io_ports_pkg::OFS_IRQ_STATUS:  rd_nxt = {2'b00, irq_status_r};
			io_ports_pkg::OFS_IRQ_ENABLE:  rd_nxt = {2'b00, irq_enable_r};
			default:                       rd_nxt = 8'h00;
		endcase
	end

	// data stands only in the cycle after the strobe
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			o_rdata <= 8'h00;
		end else if (i_read) begin
			o_rdata <= rd_nxt;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset pin

	// a second watchdog request during the pulse is ignored, not stretched
	io_ports_pkg::reset_pin_state_t pin_state_r;
	logic [io_ports_pkg::DOG_CNT_W-1:0] dog_cnt_r;

	// watchdog pulls the pin low for a fixed minimum pulse
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			pin_state_r <= io_ports_pkg::PIN_IDLE;
			dog_cnt_r   <= '0;
		end else begin
			unique case (pin_state_r)
				io_ports_pkg::PIN_IDLE: begin
					if (i_watchdog_reset) begin
						pin_state_r <= io_ports_pkg::PIN_PULSE; // R10
						dog_cnt_r   <= io_ports_pkg::DOG_CNT_W'(io_ports_pkg::DOG_PULSE_CYCLES - 1);
					end
				end
				io_ports_pkg::PIN_PULSE: begin
					if (dog_cnt_r == '0) begin
						pin_state_r <= io_ports_pkg::PIN_IDLE;
					end else begin
						dog_cnt_r <= dog_cnt_r - 1'b1;
					end
				end
				default: pin_state_r <= io_ports_pkg::PIN_IDLE;
			endcase
		end
	end

	// only ever pulls low; the board pull-up brings the pin back
	assign o_reset_pin    = 1'b0;
	assign o_reset_pin_oe = (pin_state_r == io_ports_pkg::PIN_PULSE); // R10

	// the pin level itself, registered, resets the rest of the device
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			o_device_reset_n <= 1'b0;
		end else begin
			o_device_reset_n <= i_reset_pin_n; // R10
		end
	end

endmodule : three_port_io_with_wakeup

`default_nettype wire

// >>> verification/board_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_pins_model (
	// design drive
	input  wire logic [7:0] i_a_out,
	input  wire logic [7:0] i_a_oe,
	input  wire logic [7:0] i_b_out,
	input  wire logic [7:0] i_b_oe,
	input  wire logic [5:0] i_c_out,
	input  wire logic [5:0] i_c_oe,
	input  wire logic       i_rst_oe,
	// board levels where nothing drives
	input  wire logic [7:0] i_a_ext,
	input  wire logic [7:0] i_b_ext,
	input  wire logic [5:0] i_c_ext,
	// resolved pins
	output logic      [7:0] o_a_pin,
	output logic      [7:0] o_b_pin,
	output logic      [5:0] o_c_pin,
	output logic            o_rst_pin_n
);
	// a driven line shows its driver, a released one the board level
	assign o_a_pin = (i_a_oe & i_a_out) | (~i_a_oe & i_a_ext);
	assign o_b_pin = (i_b_oe & i_b_out) | (~i_b_oe & i_b_ext);
	assign o_c_pin = (i_c_oe & i_c_out) | (~i_c_oe & i_c_ext);
	// board pull-up on the reset line wins unless pulled low
	assign o_rst_pin_n = ~i_rst_oe;
endmodule : board_pins_model
`default_nettype wire

// >>> verification/three_port_io_with_wakeup_chk.sv
`timescale 1ns/1ps
`default_nettype none
module io_ports_chk #(
	parameter bit WAKEUP_OPTION     = 1'b1,
	parameter bit OPEN_DRAIN_OPTION = 1'b0,
	parameter bit CAPTURE_OPTION    = 1'b1,
	parameter bit COMPARE_OPTION    = 1'b1
) (
	// watched ports
	input wire logic       i_clock,
	input wire logic       i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic       i_write,
	input wire logic       i_read,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_first_port_lines,
	input wire logic [7:0] o_first_port_lines_oe,
	input wire logic [5:0] i_third_port_lines,
	input wire logic [5:0] o_third_port_lines,
	input wire logic [5:0] o_third_port_lines_oe,
	input wire logic [5:0] o_third_port_pullup_en,
	input wire logic       o_timer_capture_input,
	input wire logic       i_timer_compare_output_one,
	input wire logic       o_irq,
	input wire logic       o_wakeup,
	input wire logic       i_reset_pin_n,
	input wire logic       o_reset_pin,
	input wire logic       o_reset_pin_oe,
	input wire logic       i_watchdog_reset
);
	logic [1:0] up_r;
	logic [5:0] prev_r;
	wire logic  fall = WAKEUP_OPTION && |(prev_r & ~i_third_port_lines);
	// internal reset lifts two edges after release, so wait it out
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	end
	// mirror of the edge detector, all ones while held
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) prev_r <= 6'h3f;
		else prev_r <= (up_r < 2'h2) ? 6'h3f : i_third_port_lines;
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn || up_r != 2'h3);
	AST_WAKE: assert property (fall |=> o_wakeup) else $error("no wake pulse");
	AST_NO_WAKE: assert property (!fall |=> !o_wakeup) else $error("stray wake");
	AST_IRQ_CAUSE: assert property ($rose(o_irq) |-> o_wakeup || $past(i_write))
		else $error("irq without cause");
	AST_CMP: assert property (COMPARE_OPTION |-> o_third_port_lines_oe[1]
		&& !o_third_port_pullup_en[1] && o_third_port_lines[1] == i_timer_compare_output_one)
		else $error("cmp pin");
	AST_CAP: assert property (o_timer_capture_input
		== (CAPTURE_OPTION ? i_third_port_lines[0] : 1'b1)
		&& (!CAPTURE_OPTION || !o_third_port_pullup_en[0])) else $error("capture pin");
	AST_C_IN: assert property (o_third_port_pullup_en[5:2] == ~o_third_port_lines_oe[5:2]
		&& (!WAKEUP_OPTION || o_third_port_lines_oe[5:2] == 4'h0))
		else $error("third port not input");
	AST_OE_A: assert property (!(i_write && (i_addr == io_ports_pkg::OFS_PORT_A_DIR
		|| (OPEN_DRAIN_OPTION && i_addr == io_ports_pkg::OFS_PORT_A_DATA)))
		|=> $stable(o_first_port_lines_oe)) else $error("oe moved");
	AST_OD: assert property (OPEN_DRAIN_OPTION |-> o_first_port_lines == 8'h00)
		else $error("open drain drives high");
	AST_RDATA: assert property (!$past(i_read) |-> o_rdata == 8'h00) else $error("rdata");
	AST_DOG: assert property (i_watchdog_reset && !o_reset_pin_oe
		|=> o_reset_pin_oe [*2] ##1 !o_reset_pin_oe) else $error("dog pulse");
	AST_PIN_LOW: assert property (o_reset_pin == 1'b0) else $error("reset pin high");
	cover property (o_irq);
	cover property (o_wakeup);
	cover property (o_reset_pin_oe);
endmodule : io_ports_chk
bind three_port_io_with_wakeup io_ports_chk #(
	.WAKEUP_OPTION(WAKEUP_OPTION), .OPEN_DRAIN_OPTION(OPEN_DRAIN_OPTION),
	.CAPTURE_OPTION(CAPTURE_OPTION), .COMPARE_OPTION(COMPARE_OPTION)
) chk (
	.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_write(i_write),
	.i_read(i_read), .o_rdata(o_rdata), .o_first_port_lines(o_first_port_lines),
	.o_first_port_lines_oe(o_first_port_lines_oe), .i_third_port_lines(i_third_port_lines),
	.o_third_port_lines(o_third_port_lines), .o_third_port_lines_oe(o_third_port_lines_oe),
	.o_third_port_pullup_en(o_third_port_pullup_en),
	.o_timer_capture_input(o_timer_capture_input),
	.i_timer_compare_output_one(i_timer_compare_output_one), .o_irq(o_irq),
	.o_wakeup(o_wakeup), .i_reset_pin_n(i_reset_pin_n), .o_reset_pin(o_reset_pin),
	.o_reset_pin_oe(o_reset_pin_oe), .i_watchdog_reset(i_watchdog_reset)
);
`default_nettype wire

// >>> verification/tb_three_port_io_with_wakeup.sv
`timescale 1ns/1ps
`default_nettype none
module tb_three_port_io_with_wakeup;
	logic       clock = 1'b0;
	logic       resetn = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic       wr_s = 1'b0, rd_s = 1'b0, cmp = 1'b1, wd = 1'b0;
	logic [7:0] ext_a = 8'h00, ext_b = 8'h00, a_pin, b_pin, a_out, a_oe, b_out, b_oe;
	logic [5:0] ext_c = 6'h3f, c_pin, c_out, c_oe, pull;
	logic       cap, irq, wake, rst_oe, rst_pin_n, dev_n;
	logic [7:0] rd2, a2_pin, a2_out, a2_oe, b2_pin, b2_out, b2_oe;
	logic [5:0] c2_pin, c2_out, c2_oe, pull2;
	logic       cap2, irq2;
	int         n_fail = 0, tests_run = 0;
	logic [7:0] rst_exp [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};
	always #2 clock = ~clock;
	three_port_io_with_wakeup dut (.i_clock(clock), .i_resetn(resetn), .i_addr(addr),
		.i_wdata(wdata), .i_write(wr_s), .i_read(rd_s), .o_rdata(rdata),
		.i_first_port_lines(a_pin), .o_first_port_lines(a_out), .o_first_port_lines_oe(a_oe),
		.i_second_port_lines(b_pin), .o_second_port_lines(b_out), .o_second_port_lines_oe(b_oe),
		.i_third_port_lines(c_pin), .o_third_port_lines(c_out), .o_third_port_lines_oe(c_oe),
		.o_third_port_pullup_en(pull), .o_timer_capture_input(cap),
		.i_timer_compare_output_one(cmp), .o_irq(irq), .o_wakeup(wake),
		.i_reset_pin_n(rst_pin_n), .o_reset_pin(), .o_reset_pin_oe(rst_oe),
		.i_watchdog_reset(wd), .o_device_reset_n(dev_n));
	board_pins_model board (.i_a_out(a_out), .i_a_oe(a_oe), .i_b_out(b_out), .i_b_oe(b_oe),
		.i_c_out(c_out), .i_c_oe(c_oe), .i_rst_oe(rst_oe), .i_a_ext(ext_a), .i_b_ext(ext_b),
		.i_c_ext(ext_c), .o_a_pin(a_pin), .o_b_pin(b_pin), .o_c_pin(c_pin),
		.o_rst_pin_n(rst_pin_n));
	// second build: open-drain first port, plain third port, no timer pins
	three_port_io_with_wakeup #(.WAKEUP_OPTION(1'b0), .OPEN_DRAIN_OPTION(1'b1),
		.CAPTURE_OPTION(1'b0), .COMPARE_OPTION(1'b0)) dut_alt (.i_clock(clock),
		.i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_write(wr_s), .i_read(rd_s),
		.o_rdata(rd2), .i_first_port_lines(a2_pin), .o_first_port_lines(a2_out),
		.o_first_port_lines_oe(a2_oe), .i_second_port_lines(b2_pin),
		.o_second_port_lines(b2_out), .o_second_port_lines_oe(b2_oe),
		.i_third_port_lines(c2_pin), .o_third_port_lines(c2_out), .o_third_port_lines_oe(c2_oe),
		.o_third_port_pullup_en(pull2), .o_timer_capture_input(cap2),
		.i_timer_compare_output_one(cmp), .o_irq(irq2), .o_wakeup(),
		.i_reset_pin_n(rst_pin_n), .o_reset_pin(), .o_reset_pin_oe(),
		.i_watchdog_reset(wd), .o_device_reset_n());
	board_pins_model board_alt (.i_a_out(a2_out), .i_a_oe(a2_oe), .i_b_out(b2_out),
		.i_b_oe(b2_oe), .i_c_out(c2_out), .i_c_oe(c2_oe), .i_rst_oe(1'b0), .i_a_ext(ext_a),
		.i_b_ext(ext_b), .i_c_ext(ext_c), .o_a_pin(a2_pin), .o_b_pin(b2_pin),
		.o_c_pin(c2_pin), .o_rst_pin_n());
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask : chk
	// strobes drop one edge later, so back-to-back calls leave a gap
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clock);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock);
		rd_s <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////
	// a hang is cut off here, far beyond the length of the whole test
	initial begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		// reset state of every register, then an unmapped offset
		for (int k = 0; k < 10; k++) rd((k == 9) ? 8'h0f : 8'(k), rst_exp[k]);
		wr(8'h0f, 8'hff);
		rd(8'h0f, 8'h00);
		ext_a <= 8'hc3;
		wr(8'h01, 8'hff);
		wr(8'h00, 8'h5a);
		// latches land at this edge, so look once they have settled
		#1 chk(a_oe, 8'hff);
		chk(a_out, 8'h5a);
		chk(a2_oe, 8'ha5);
		chk(a2_out, 8'h00);
		wr(8'h01, 8'h0f);
		rd(8'h00, 8'hca);
		chk(a2_pin, 8'hc2);
		chk(rd2, 8'hca);
		ext_b <= 8'h99;
		wr(8'h03, 8'hf0);
		wr(8'h02, 8'h3c);
		chk(b_oe, 8'hf0);
		rd(8'h02, 8'h39);
		// wake-up build keeps the third port as inputs whatever the direction, except the compare pin on bit one
		wr(8'h05, 8'h3f);
		wr(8'h04, 8'h15);
		rd(8'h04, 8'h3f);
		chk(rd2, 8'h15);
		chk({2'h0, c_oe}, 8'h02);
		chk({2'h0, pull}, 8'h3c);
		chk({2'h0, c2_oe}, 8'h3f);
		chk({2'h0, pull2}, 8'h00);
		wr(8'h08, 8'h08);
		ext_c <= 6'h17;
		@(posedge clock);
		#1 chk({7'h0, wake}, 8'h01);
		@(posedge clock);
		#1 chk({7'h0, wake}, 8'h00);
		@(posedge clock);
		#1 chk({7'h0, irq}, 8'h01);
		chk({7'h0, irq2}, 8'h00);
		wr(8'h06, 8'hff);
		rd(8'h06, 8'h28);
		wr(8'h07, 8'h08);
		#1 chk({7'h0, irq}, 8'h00);
		rd(8'h06, 8'h20);
		wr(8'h07, 8'h20);
		rd(8'h06, 8'h00);
		// a low capture pin reaches the timer; the plain build holds it high
		@(posedge clock);
		ext_c <= 6'h16;
		#1 chk({7'h0, cap}, 8'h00);
		wr(8'h05, 8'h00);
		rd(8'h04, 8'h16);
		chk(rd2, 8'h16);
		chk({2'h0, pull2}, 8'h3f);
		chk({7'h0, cap2}, 8'h01);
		@(posedge clock);
		wd <= 1'b1;
		@(posedge clock);
		wd <= 1'b0;
		#1 chk({7'h0, rst_oe}, 8'h01);
		@(posedge clock);
		#1 chk({7'h0, dev_n}, 8'h00);
		repeat (4) @(posedge clock);
		#1 chk({7'h0, dev_n}, 8'h01);
		tally_and_finish();
	end
endmodule : tb_three_port_io_with_wakeup
`default_nettype wire
